// ---- bench/fps_front_model.sv ----
`timescale 1ns/100ps
module fps_front_model (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [13:0] f1_set,
	input  wire logic [13:0] f2_set,
	input  wire logic [7:0]  blk_set,
	output logic      [13:0] freq_first_voltage_transformer_input,
	output logic      [13:0] freq_second_voltage_transformer_input,
	output logic      [7:0]  stage_block
);
	// tracking front end and blocking matrix, re-registered every cycle
	// nominal 50 hz during reset so no stage sees a bogus swing at release
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			freq_first_voltage_transformer_input  <= 14'h1388;
			freq_second_voltage_transformer_input <= 14'h1388;
			stage_block                           <= 8'h00;
		end else begin
			freq_first_voltage_transformer_input  <= f1_set;
			freq_second_voltage_transformer_input <= f2_set;
			stage_block                           <= blk_set;
		end
	end
endmodule

// ---- bench/frequency_protection_stages_bench.sv ----
`timescale 1ns/100ps
module frequency_protection_stages_bench import fps_pkg::*; ;
	localparam int MC = 20;
	logic        sys_clk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [13:0] f1_set;
	logic [13:0] f2_set;
	logic [7:0]  blk_set;
	logic [13:0] freq_a;
	logic [13:0] freq_b;
	logic [7:0]  stage_block;
	logic [7:0]  stage_start;
	logic [7:0]  stage_trip;
	logic [7:0]  stage_blocked;
	logic        evt_valid;
	logic [2:0]  evt_stage;
	logic [2:0]  evt_mask;
	logic [2:0]  evt_level;
	logic [31:0] evt_stamp;
	logic        irq;
	logic [2:0]  ev_mask [8];
	logic [2:0]  ev_lvl [8];
	int          ev_cnt = 0;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;
	int          e0;
	logic [31:0] t0;
	logic [31:0] t1;
	logic        se;
	logic [31:0] ev_st;

	fps_front_model fm (
		.sys_clk                               (sys_clk),
		.sys_rst                               (sys_rst),
		.f1_set                                (f1_set),
		.f2_set                                (f2_set),
		.blk_set                               (blk_set),
		.freq_first_voltage_transformer_input  (freq_a),
		.freq_second_voltage_transformer_input (freq_b),
		.stage_block                           (stage_block)
	);

	// short measurement and stamp periods keep the run small
	fps_top #(.MEAS_CYCLES(MC), .STAMP_CYCLES(4)) uut (
		.sys_clk                               (sys_clk),
		.sys_rst                               (sys_rst),
		.psel                                  (psel),
		.penable                               (penable),
		.pwrite                                (pwrite),
		.paddr                                 (paddr),
		.pwdata                                (pwdata),
		.prdata                                (prdata),
		.pready                                (pready),
		.pslverr                               (pslverr),
		.freq_first_voltage_transformer_input  (freq_a),
		.freq_second_voltage_transformer_input (freq_b),
		.stage_block                           (stage_block),
		.stage_start                           (stage_start),
		.stage_trip                            (stage_trip),
		.stage_blocked                         (stage_blocked),
		.evt_valid                             (evt_valid),
		.evt_stage                             (evt_stage),
		.evt_mask                              (evt_mask),
		.evt_level                             (evt_level),
		.evt_stamp                             (evt_stamp),
		.irq                                   (irq)
	);

	////////////////////////////////////////////////////////////////
	// clock, event capture and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (evt_valid === 1'b1) begin
			ev_mask[evt_stage] <= evt_mask;
			ev_lvl[evt_stage]  <= evt_level;
			ev_st              <= evt_stamp;
			ev_cnt             <= ev_cnt + 1;
		end
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_total++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	// access and compare tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// request held until pready, then one idle edge so psel is never driven twice in a step
	// no local limit: a stuck slave is caught by the hang guard and fails the run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        s;
		apb(1'b1, a, d, r, s);
	endtask

	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		logic        s;
		apb(1'b0, a, 32'h0, r, s);
		chk(n, e, r);
	endtask

	task automatic setw(input int g, input int s, input logic [12:0] p, input logic [18:0] t);
		wr(12'h100 + 12'((g * 8 + s) * 4), {t, p});
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// three measurement periods: at least one whole scan after the change
	task automatic fq(input logic [13:0] a, input logic [13:0] b);
		f1_set <= a;
		f2_set <= b;
		waitc(3 * MC);
	endtask

	task automatic outs(input logic [7:0] s, input logic [7:0] t, input logic [7:0] b);
		chk("start", 32'(s), 32'(stage_start));
		chk("trip", 32'(t), 32'(stage_trip));
		chk("blocked", 32'(b), 32'(stage_blocked));
	endtask

	task automatic wrap_up();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		f1_set = 14'h1388;
		f2_set = 14'h1388;
		blk_set = 8'h00;
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rdc("ctrl", ADDR_CTRL, 32'(CTRL_RST));
		rdc("enable", ADDR_EN, 32'h5555);
		rdc("force", ADDR_FORCE, 32'h0);
		rdc("irq_en", ADDR_IRQ_EN, 32'h0);
		apb(1'b0, 12'h0f0, 32'h0, t0, se);
		chk("slverr", 32'h1, 32'(se));
		// group 1 moves only the first over stage pick-up
		for (int g = 0; g < 2; g++) begin
			setw(g, 0, g ? 13'h13ba : 13'h13ec, 19'h0_0000);
			setw(g, 1, 13'h1450, 19'h0_0004);
			setw(g, 4, 13'h1324, 19'h0_0000);
		end
		// setting window read goes through the ram wait state
		rdc("set_word", 12'h104, 32'h0000_9450);
		wr(ADDR_EN, 32'h565a);
		wr(ADDR_IRQ_EN, 32'h0007);
		wr(ADDR_CTRL, 32'h00c1);
		fq(14'h1388, 14'h1388);
		outs(8'h00, 8'h00, 8'h00);
		apb(1'b0, ADDR_STAMP, 32'h0, t0, se);
		fq(14'h13ed, 14'h1388);
		outs(8'h01, 8'h01, 8'h00);
		apb(1'b0, ADDR_STAMP, 32'h0, t1, se);
		chk("evt_stamp", 32'h1, 32'(ev_st >= t0 && ev_st <= t1));
		chk("evt_mask", 32'h3, 32'(ev_mask[0]));
		chk("evt_level", 32'h3, 32'(ev_lvl[0]));
		rdc("irq_stat", ADDR_IRQ_STAT, 32'h3);
		chk("irq", 32'h1, 32'(irq));
		rdc("cnt_start", ADDR_CNT_ST, 32'h1);
		rdc("cnt_trip", ADDR_CNT_TR, 32'h1);
		wr(ADDR_CNT_CLR, 32'h0007);
		rdc("cnt_start", ADDR_CNT_ST, 32'h0);
		wr(ADDR_IRQ_EN, 32'h0);
		chk("irq", 32'h0, 32'(irq));
		wr(ADDR_IRQ_CLR, 32'h0007);
		rdc("irq_stat", ADDR_IRQ_STAT, 32'h0);
		wr(ADDR_IRQ_EN, 32'h0007);
		fq(14'h13eb, 14'h1388);
		outs(8'h01, 8'h01, 8'h00);
		fq(14'h13e9, 14'h1388);
		outs(8'h00, 8'h00, 8'h00);
		chk("evt_level", 32'h0, 32'(ev_lvl[0]));
		// delayed stage: at most two scans seen first, then at least five
		f1_set <= 14'h1451;
		waitc(40);
		outs(8'h03, 8'h01, 8'h00);
		waitc(80);
		outs(8'h03, 8'h03, 8'h00);
		fq(14'h1388, 14'h1388);
		fq(14'h1323, 14'h1388);
		outs(8'h10, 8'h10, 8'h00);
		fq(14'h1388, 14'h1388);
		blk_set <= 8'h10;
		fq(14'h1323, 14'h1388);
		outs(8'h00, 8'h00, 8'h10);
		chk("evt_mask", 32'h4, 32'(ev_mask[4]));
		rdc("status", ADDR_STATUS, 32'h0010_0000);
		rdc("meas", ADDR_MEAS, 32'h0000_1323);
		rdc("cnt_block", ADDR_CNT_BK, 32'h1);
		blk_set <= 8'h00;
		fq(14'h1388, 14'h1388);
		wr(ADDR_CTRL, 32'h00c5);
		fq(14'h13ed, 14'h1388);
		outs(8'h00, 8'h00, 8'h00);
		fq(14'h1388, 14'h13ed);
		outs(8'h01, 8'h01, 8'h00);
		wr(ADDR_CTRL, 32'h00c1);
		fq(14'h13c4, 14'h1388);
		outs(8'h00, 8'h00, 8'h00);
		wr(ADDR_CTRL, 32'h00c9);
		waitc(3 * MC);
		outs(8'h01, 8'h01, 8'h00);
		// off events not stored, so the release leaves no word
		wr(ADDR_CTRL, 32'h0049);
		e0 = ev_cnt;
		fq(14'h1388, 14'h1388);
		outs(8'h00, 8'h00, 8'h00);
		chk("evt_cnt", 32'(e0), 32'(ev_cnt));
		wr(ADDR_CTRL, 32'h00c1);
		fq(14'h13ed, 14'h1388);
		wr(ADDR_CTRL, 32'h00c0);
		e0 = ev_cnt;
		waitc(3 * MC);
		outs(8'h00, 8'h00, 8'h00);
		chk("evt_cnt", 32'(e0), 32'(ev_cnt));
		fq(14'h1388, 14'h1388);
		wr(ADDR_CTRL, 32'h00c1);
		wr(ADDR_FORCE, 32'h0002);
		waitc(3 * MC);
		outs(8'h00, 8'h00, 8'h00);
		wr(ADDR_CTRL, 32'h00c3);
		for (int c = 1; c < 4; c++) begin
			wr(ADDR_FORCE, 32'(c));
			waitc(3 * MC);
			outs({7'h0, c != 3}, {7'h0, c == 2}, {7'h0, c == 3});
		end
		wr(ADDR_CTRL, 32'h00cb);
		waitc(3 * MC);
		outs(8'h00, 8'h00, 8'h01);
		rdc("force", ADDR_FORCE, 32'h0003);
		rdc("enable", ADDR_EN, 32'h565a);
		// two stamp reads exactly 40 cycles apart
		apb(1'b0, ADDR_STAMP, 32'h0, t0, se);
		waitc(37);
		apb(1'b0, ADDR_STAMP, 32'h0, t1, se);
		chk("stamp_step", 32'h000a, t1 - t0);
		wrap_up();
	end
endmodule

// ---- logic/fps_mem_if.sv ----
`timescale 1ns/100ps
interface fps_mem_if;
	logic        wr_en;
	logic [5:0]  wr_addr;
	logic [31:0] wr_data;
	logic        rd_en;
	logic [5:0]  rd_addr;
	logic [31:0] rd_data;

	modport ram (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
	modport user (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
endinterface

// ---- logic/fps_pkg.sv ----
package fps_pkg;

	////////////////////////////////////////////////////////////////////////
	// time base
	localparam int CLK_PERIOD_NS    = 8;
	localparam int MEAS_BASE_US     = 5000;
	localparam int STAMP_RES_US     = 1000;
	localparam int MEAS_CYCLES_DEF  = MEAS_BASE_US * 1000 / CLK_PERIOD_NS;
	localparam int STAMP_CYCLES_DEF = STAMP_RES_US * 1000 / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// stage layout: 0..3 over, 4..7 under
	localparam int NUM_OVER  = 4;
	localparam int NUM_UNDER = 4;
	localparam int NUM_STAGE = NUM_OVER + NUM_UNDER;
	localparam int NUM_GROUP = 8;

	// frequency codes are in 10 mHz steps
	localparam int          FREQ_LSB_MHZ = 10;
	localparam int          HYST_MHZ     = 20;
	localparam logic [13:0] HYST_CODES   = 14'(HYST_MHZ / FREQ_LSB_MHZ);

	// enable and force codes
	localparam logic [1:0] EN_NO        = 2'h1;
	localparam logic [1:0] EN_YES       = 2'h2;
	localparam logic [1:0] FORCE_NORMAL = 2'h0;
	localparam logic [1:0] FORCE_START  = 2'h1;
	localparam logic [1:0] FORCE_TRIP   = 2'h2;
	localparam logic [1:0] FORCE_BLOCK  = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [11:0] ADDR_CTRL     = 12'h000;
	localparam logic [11:0] ADDR_EN       = 12'h004;
	localparam logic [11:0] ADDR_FORCE    = 12'h008;
	localparam logic [11:0] ADDR_STATUS   = 12'h00c;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
	localparam logic [11:0] ADDR_IRQ_CLR  = 12'h014;
	localparam logic [11:0] ADDR_IRQ_EN   = 12'h018;
	localparam logic [11:0] ADDR_CNT_CLR  = 12'h01c;
	localparam logic [11:0] ADDR_CNT_ST   = 12'h020;
	localparam logic [11:0] ADDR_CNT_TR   = 12'h024;
	localparam logic [11:0] ADDR_CNT_BK   = 12'h028;
	localparam logic [11:0] ADDR_STAMP    = 12'h02c;
	localparam logic [11:0] ADDR_MEAS     = 12'h030;
	localparam logic [3:0]  SET_WIN_PAGE  = 4'h1;

	// control fields
	localparam int CTRL_MODE_BIT  = 0;
	localparam int CTRL_FORCE_BIT = 1;
	localparam int CTRL_REF_BIT   = 2;
	localparam int CTRL_GRP_LSB   = 3;
	localparam int CTRL_ON_BIT    = 6;
	localparam int CTRL_OFF_BIT   = 7;

	// setting word fields
	localparam int          SET_PICK_LSB = 0;
	localparam int          SET_TIME_LSB = 13;
	localparam logic [18:0] TMR_MAX      = 19'h7_ffff;

	// reset values
	localparam logic [7:0]  CTRL_RST   = 8'hc0;
	localparam logic [15:0] EN_RST     = 16'h5555;
	localparam logic [15:0] FORCE_RST  = 16'h0000;
	localparam logic [2:0]  IRQ_EN_RST = 3'h0;
	localparam logic [3:0]  SCAN_LAST  = 4'h8;

	typedef enum logic {FPS_IDLE, FPS_SCAN} fps_scan_t;

endpackage

// ---- logic/fps_set_ram.sv ----
`timescale 1ns/100ps
module fps_set_ram (
	input wire logic sys_clk,
	fps_mem_if.ram   mem
);
	// one word per group and stage; no reset, software loads it
	logic [31:0] store [64];
	logic [31:0] rd_data_reg;

	// write port
	always_ff @(posedge sys_clk) begin
		if (mem.wr_en) begin
			store[mem.wr_addr] <= mem.wr_data;
		end
	end

	// registered read, holds between reads
	always_ff @(posedge sys_clk) begin
		if (mem.rd_en) begin
			rd_data_reg <= store[mem.rd_addr];
		end
	end

	assign mem.rd_data = rd_data_reg;
endmodule

// ---- logic/fps_top.sv ----
// Overview of operation
// - four over and four under stages
// - stage active only with mode on
// - enable code 1 off, 2 on, default off
// - eight setting groups, one shared selector
// - instant or time delayed operation
// - compare frequency against pick-up in 10 mHz steps
// - reference from first or second transformer, 5 ms
// - start, trip, blocked outputs per stage
// - on and off events per output
// - instant start and trip share stamp
// - stamps count whole milliseconds
// - clearable start, trip, blocked counters
// - forced status only with global forcing
// - enable and force independent of group
// - over above setting, under below setting
// - release hysteresis of 20 mHz
// - blocked instead of start when blocking; a block arriving after pick-up drops start and shows no blocked
// - on, off or both events selectable
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module fps_top
	import fps_pkg::*;
#(
	parameter int MEAS_CYCLES  = MEAS_CYCLES_DEF,
	parameter int STAMP_CYCLES = STAMP_CYCLES_DEF
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [13:0] freq_first_voltage_transformer_input,
	input  wire logic [13:0] freq_second_voltage_transformer_input,
	input  wire logic [7:0]  stage_block,
	output logic      [7:0]  stage_start,
	output logic      [7:0]  stage_trip,
	output logic      [7:0]  stage_blocked,
	output logic             evt_valid,
	output logic      [2:0]  evt_stage,
	output logic      [2:0]  evt_mask,
	output logic      [2:0]  evt_level,
	output logic      [31:0] evt_stamp,
	output logic             irq
);
	fps_mem_if mem ();

	logic [7:0]  ctrl_reg;
	logic [15:0] stage_en_reg;
	logic [15:0] force_reg;
	logic [2:0]  irq_stat_reg;
	logic [2:0]  irq_en_reg;
	logic [15:0] cnt_start_reg;
	logic [15:0] cnt_trip_reg;
	logic [15:0] cnt_blk_reg;
	logic [31:0] meas_cnt_reg;
	logic [31:0] ms_cnt_reg;
	logic [31:0] stamp_reg;
	fps_scan_t   state_reg;
	logic [3:0]  scan_idx_reg;
	logic [13:0] meas_reg;
	logic [2:0]  grp_reg;
	logic        proc_valid_reg;
	logic [2:0]  proc_idx_reg;
	logic        apb_rd_wait_reg;
	logic [7:0]  pick_reg;
	logic [7:0]  hold_start_reg;
	logic [7:0]  hold_blk_reg;
	logic [18:0] tmr_reg [NUM_STAGE];
	logic [7:0]  out_start_reg;
	logic [7:0]  out_trip_reg;
	logic [7:0]  out_blk_reg;
	logic        evt_valid_reg;
	logic [2:0]  evt_stage_reg;
	logic [2:0]  evt_mask_reg;
	logic [2:0]  evt_level_reg;
	logic [31:0] evt_stamp_reg;

	logic        apb_acc;
	logic        set_win;
	logic        reg_hit;
	logic        apb_rd_go;
	logic        scan_rd;
	logic        meas_tick;
	logic        ms_tick;
	logic [31:0] rd_val;
	logic [2:0]  irq_clr;
	logic [2:0]  cnt_clr;
	logic [7:0]  stage_act;
	logic [7:0]  stage_frc;
	logic [2:0]  p;
	logic [13:0] set_pick;
	logic [18:0] set_time;
	logic        pk_raw;
	logic        pk_keep;
	logic        pk_n;
	logic        st_n;
	logic        tr_n;
	logic        bk_n;
	logic [18:0] tm_n;
	logic [2:0]  lvl_n;
	logic [2:0]  lvl_o;
	logic [2:0]  keep_mask;
	logic [2:0]  rise;

	fps_set_ram u_ram (
		.sys_clk (sys_clk),
		.mem     (mem)
	);

	////////////////////////////////////////////////////////////////////////
	// apb decode; setting window reads wait one cycle for the ram, longer while a scan is reading it
	assign apb_acc   = psel & penable;
	assign set_win   = (paddr[11:8] == SET_WIN_PAGE) && (paddr[1:0] == 2'h0);
	assign apb_rd_go = apb_acc & ~pwrite & set_win & ~apb_rd_wait_reg & ~scan_rd;
	assign pready    = ~(set_win & ~pwrite) | apb_rd_wait_reg;
	assign pslverr   = apb_acc & pready & ~(set_win | reg_hit);
	assign prdata    = rd_val;
	assign irq_clr   = (apb_acc && pwrite && paddr == ADDR_IRQ_CLR) ? pwdata[2:0] : 3'h0;
	assign cnt_clr   = (apb_acc && pwrite && paddr == ADDR_CNT_CLR) ? pwdata[2:0] : 3'h0;

	// ram ports: scan has priority, apb read stalls on pready
	assign mem.wr_en   = apb_acc & pwrite & set_win;
	assign mem.wr_addr = paddr[7:2];
	assign mem.wr_data = pwdata;
	assign mem.rd_en   = scan_rd | apb_rd_go;
	assign mem.rd_addr = scan_rd ? {grp_reg, scan_idx_reg[2:0]} : paddr[7:2];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			apb_rd_wait_reg <= 1'b0;
		end else begin
			apb_rd_wait_reg <= apb_rd_go;
		end
	end

	// register readback
	always_comb begin
		rd_val  = 32'h0000_0000;
		reg_hit = 1'b1;
		case (paddr)
			ADDR_CTRL:     rd_val = {24'h00_0000, ctrl_reg};
			ADDR_EN:       rd_val = {16'h0000, stage_en_reg};
			ADDR_FORCE:    rd_val = {16'h0000, force_reg};
			ADDR_STATUS:   rd_val = {8'h00, out_blk_reg, out_trip_reg, out_start_reg};
			ADDR_IRQ_STAT: rd_val = {29'h0000_0000, irq_stat_reg};
			ADDR_IRQ_CLR:  rd_val = 32'h0000_0000;
			ADDR_IRQ_EN:   rd_val = {29'h0000_0000, irq_en_reg};
			ADDR_CNT_CLR:  rd_val = 32'h0000_0000;
			ADDR_CNT_ST:   rd_val = {16'h0000, cnt_start_reg};
			ADDR_CNT_TR:   rd_val = {16'h0000, cnt_trip_reg};
			ADDR_CNT_BK:   rd_val = {16'h0000, cnt_blk_reg};
			ADDR_STAMP:    rd_val = stamp_reg;
			ADDR_MEAS:     rd_val = {18'h0_0000, meas_reg};
			default:       reg_hit = 1'b0;
		endcase
		if (set_win) begin
			rd_val = mem.rd_data;
		end
	end

	// static settings, untouched by group changes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_reg     <= CTRL_RST;
			stage_en_reg <= EN_RST;
			force_reg    <= FORCE_RST;
			irq_en_reg   <= IRQ_EN_RST;
		end else if (apb_acc && pwrite) begin
			if (paddr == ADDR_CTRL) ctrl_reg <= pwdata[7:0];
			if (paddr == ADDR_EN) stage_en_reg <= pwdata[15:0];
			if (paddr == ADDR_FORCE) force_reg <= pwdata[15:0];
			if (paddr == ADDR_IRQ_EN) irq_en_reg <= pwdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per stage activation and forcing decode
	for (genvar i = 0; i < NUM_STAGE; i++) begin : g_stage
		assign stage_act[i] = ctrl_reg[CTRL_MODE_BIT] && (stage_en_reg[2*i +: 2] == EN_YES);
		assign stage_frc[i] = ctrl_reg[CTRL_FORCE_BIT] && (force_reg[2*i +: 2] != FORCE_NORMAL);
	end

	////////////////////////////////////////////////////////////////////////
	// measurement tick and millisecond stamp
	assign meas_tick = (meas_cnt_reg == 32'(MEAS_CYCLES - 1));
	assign ms_tick   = (ms_cnt_reg == 32'(STAMP_CYCLES - 1));

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meas_cnt_reg <= 32'h0000_0000;
		end else begin
			meas_cnt_reg <= meas_tick ? 32'h0000_0000 : meas_cnt_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ms_cnt_reg <= 32'h0000_0000;
			stamp_reg  <= 32'h0000_0000;
		end else begin
			ms_cnt_reg <= ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
			if (ms_tick) stamp_reg <= stamp_reg + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scan: one ram read per stage, processing a cycle later
	assign scan_rd = (state_reg == FPS_SCAN) && !scan_idx_reg[3];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg    <= FPS_IDLE;
			scan_idx_reg <= 4'h0;
			meas_reg     <= 14'h0000;
			grp_reg      <= 3'h0;
		end else begin
			unique case (state_reg)
				FPS_IDLE: begin
					scan_idx_reg <= 4'h0;
					if (meas_tick) begin
						state_reg <= FPS_SCAN;
						// group and reference frozen for the whole scan
						grp_reg  <= ctrl_reg[CTRL_GRP_LSB +: 3];
						meas_reg <= ctrl_reg[CTRL_REF_BIT] ? freq_second_voltage_transformer_input
							: freq_first_voltage_transformer_input;
					end
				end
				FPS_SCAN: begin
					scan_idx_reg <= scan_idx_reg + 4'h1;
					if (scan_idx_reg == SCAN_LAST) state_reg <= FPS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			proc_valid_reg <= 1'b0;
			proc_idx_reg   <= 3'h0;
		end else begin
			proc_valid_reg <= scan_rd;
			proc_idx_reg   <= scan_idx_reg[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stage evaluation for the stage under processing
	always_comb begin
		p        = proc_idx_reg;
		set_pick = {1'b0, mem.rd_data[SET_PICK_LSB +: 13]};
		set_time = mem.rd_data[SET_TIME_LSB +: 19];
		if (p[2]) begin
			pk_raw  = meas_reg < set_pick;
			pk_keep = {1'b0, meas_reg} <= ({1'b0, set_pick} + {1'b0, HYST_CODES});
		end else begin
			pk_raw  = meas_reg > set_pick;
			pk_keep = ({1'b0, meas_reg} + {1'b0, HYST_CODES}) >= {1'b0, set_pick};
		end
		pk_n = stage_act[p] && (pick_reg[p] ? pk_keep : pk_raw);
		st_n = 1'b0;
		bk_n = 1'b0;
		tr_n = 1'b0;
		tm_n = 19'h0_0000;
		if (pk_n) begin
			if (!pick_reg[p]) begin
				bk_n = stage_block[p];
				st_n = !stage_block[p];
			end else begin
				// blocked pick-up is not timed; late block drops start
				bk_n = hold_blk_reg[p];
				st_n = hold_start_reg[p] && !stage_block[p];
			end
			if (st_n) tm_n = (tmr_reg[p] == TMR_MAX) ? TMR_MAX : tmr_reg[p] + 19'h0_0001;
			// zero time gives trip in the start cycle
			tr_n = st_n && (tm_n >= set_time);
		end
		lvl_n = {bk_n, tr_n, st_n};
		if (stage_act[p] && stage_frc[p]) begin
			case (force_reg[2*p +: 2])
				FORCE_START: lvl_n = 3'b001;
				FORCE_TRIP:  lvl_n = 3'b011;
				default:     lvl_n = 3'b100;
			endcase
		end
		lvl_o     = {out_blk_reg[p], out_trip_reg[p], out_start_reg[p]};
		rise      = proc_valid_reg ? (lvl_n & ~lvl_o) : 3'h0;
		// inactive stages drop outputs silently
		keep_mask = (lvl_o ^ lvl_n) & ((lvl_n & {3{ctrl_reg[CTRL_ON_BIT]}})
			| (~lvl_n & {3{ctrl_reg[CTRL_OFF_BIT]}}));
		if (!stage_act[p] || !proc_valid_reg) keep_mask = 3'h0;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pick_reg       <= 8'h00;
			hold_start_reg <= 8'h00;
			hold_blk_reg   <= 8'h00;
			out_start_reg  <= 8'h00;
			out_trip_reg   <= 8'h00;
			out_blk_reg    <= 8'h00;
			for (int k = 0; k < NUM_STAGE; k++) tmr_reg[k] <= 19'h0_0000;
		end else if (proc_valid_reg) begin
			pick_reg[p]       <= pk_n;
			hold_start_reg[p] <= st_n;
			hold_blk_reg[p]   <= bk_n;
			tmr_reg[p]        <= tm_n;
			out_start_reg[p]  <= lvl_n[0];
			out_trip_reg[p]   <= lvl_n[1];
			out_blk_reg[p]    <= lvl_n[2];
		end
	end

	assign stage_start   = out_start_reg;
	assign stage_trip    = out_trip_reg;
	assign stage_blocked = out_blk_reg;

	////////////////////////////////////////////////////////////////////////
	// events: one word per stage, shared stamp for all its changes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			evt_valid_reg <= 1'b0;
			evt_stage_reg <= 3'h0;
			evt_mask_reg  <= 3'h0;
			evt_level_reg <= 3'h0;
			evt_stamp_reg <= 32'h0000_0000;
		end else begin
			evt_valid_reg <= |keep_mask;
			evt_stage_reg <= p;
			evt_mask_reg  <= keep_mask;
			evt_level_reg <= lvl_n;
			evt_stamp_reg <= stamp_reg;
		end
	end

	assign evt_valid = evt_valid_reg;
	assign evt_stage = evt_stage_reg;
	assign evt_mask  = evt_mask_reg;
	assign evt_level = evt_level_reg;
	assign evt_stamp = evt_stamp_reg;

	// counters; an increment in the clear cycle still counts
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_start_reg <= 16'h0000;
			cnt_trip_reg  <= 16'h0000;
			cnt_blk_reg   <= 16'h0000;
		end else begin
			cnt_start_reg <= (cnt_clr[0] ? 16'h0000 : cnt_start_reg) + {15'h0000, rise[0]};
			cnt_trip_reg  <= (cnt_clr[1] ? 16'h0000 : cnt_trip_reg) + {15'h0000, rise[1]};
			cnt_blk_reg   <= (cnt_clr[2] ? 16'h0000 : cnt_blk_reg) + {15'h0000, rise[2]};
		end
	end

	// sticky interrupt status, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_stat_reg <= 3'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | rise;
		end
	end

	assign irq = |(irq_stat_reg & irq_en_reg);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_scan_run;
		(state_reg == FPS_SCAN) [*8];
	endsequence

	sequence s_scan_end;
		(state_reg == FPS_SCAN) ##1 (state_reg == FPS_IDLE);
	endsequence

	a_scan_nine_cycles: assert property ((state_reg == FPS_IDLE && meas_tick) |=> s_scan_run ##1 s_scan_end)
		else $error("scan did not take nine cycles");
	a_meas_tick_space: assert property (meas_tick |=> !meas_tick [*8])
		else $error("measurement ticks too close");
	a_blk_start_excl: assert property ((out_start_reg & out_blk_reg) == 8'h00)
		else $error("start and blocked together");
	a_trip_needs_start: assert property ((out_trip_reg & ~out_start_reg) == 8'h00)
		else $error("trip without start");
	a_inactive_quiet: assert property ((proc_valid_reg && !stage_act[proc_idx_reg])
		|=> !out_start_reg[$past(proc_idx_reg)] && !out_blk_reg[$past(proc_idx_reg)] && !evt_valid)
		else $error("inactive stage shows output");
	a_instant_trip: assert property ((proc_valid_reg && !stage_frc[p] && st_n && set_time == 19'h0_0000)
		|=> out_trip_reg[$past(proc_idx_reg)] && out_start_reg[$past(proc_idx_reg)])
		else $error("instant stage did not trip with start");
	a_evt_on_change: assert property ((keep_mask != 3'h0)
		|=> evt_valid && evt_stamp == $past(stamp_reg) && evt_mask == $past(keep_mask))
		else $error("event missing after output change");
	a_stamp_step: assert property (ms_tick |=> stamp_reg == $past(stamp_reg) + 32'h0000_0001 ##1 $stable(stamp_reg))
		else $error("stamp step wrong");
	a_cnt_clear: assert property ((cnt_clr[0] && !rise[0]) |=> cnt_start_reg == 16'h0000)
		else $error("start counter not cleared");
	a_irq_sticky: assert property ((irq_stat_reg[1] && !irq_clr[1]) |=> irq_stat_reg[1])
		else $error("sticky trip flag lost");
	a_en_reset: assert property ($past(sys_rst) |-> stage_en_reg == EN_RST)
		else $error("enable codes not at reset value");
endmodule
